// ---- src/context_switch_status.sv ----
/*
  Context save/restore sequencer and switch status reporter of one engine.
  Assumes switch events come from the engine scheduler held on sw_valid
  until sw_ready, with ids and detail, a word memory with request/acknowledge,
  and an APB master for the register file.
*/
// What this block does
// - Restore the chosen context image on switch-in; save it back on switch-out.
// - Image order is 4K status page, ring context, engine context.
// - Descriptor points to the 4KB status page base; head reported there.
// - Ring context follows the status page and spans five cache lines.
// - Restore ring context first; its save/restore control steers engine restore.
// - Engine context follows ring context, restored and saved after it.
// - Inhibit bit skips engine restore; next save still writes full engine context.
// - Every valid context switch-out reports a 64-bit switch-reason record.
// - Leaving idle for first element also reports; away id is meaningless.
// - Each reported record is followed by the context switch interrupt.
// - Masked switch reasons suppress both record and interrupt.
// - Record holds away id, to id, new-queue flag and detail.
// - Every record is also pushed to a firmware read-port FIFO.
// - Idle id is FFFF; idle-to-active has flag set, away idle, detail 0.
// - Preempt-to-idle: flag set, running away, idle target, detail 0-5.
// - Load switch detail: 0 completed, 5 preempted, 1-4 blocked wait.
// - Same context reloaded reports lite restore, flag set, equal ids.
// - Element switch: flag clear, detail 0 complete or 1-4 wait.
// - Active-to-idle: flag clear, idle target, detail 0-4 only.
// - Records go to successive buffer entries from dword 28h, wrapping.
// - Twelve entries, wrap after 11; index bits 7:4 written zero.
`timescale 1ns/100ps
module context_switch_status
  import ctx_switch_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Switch event from the execution queue logic
  input  wire logic        sw_valid,
  input  wire logic [2:0]  sw_kind,
  input  wire logic [15:0] sw_to_id,
  input  wire logic [31:0] sw_to_base,
  input  wire logic [2:0]  sw_detail,
  output logic             sw_ready,
  // Memory port
  output logic             mem_req,
  output logic             mem_we,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  // Status
  output logic             ctx_switch_irq,
  output logic      [15:0] running_id
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_SAVE_RING, ST_SAVE_ENG, ST_REST_RING, ST_REST_ENG,
    ST_REC_LO, ST_REC_HI, ST_LAST_IDX, ST_IRQ
  } seq_t;

  typedef struct packed {
    seq_t        st;
    logic        issued;
    logic [3:0]  word;
    logic [15:0] run_id;
    logic [31:0] run_base;
    logic [15:0] to_id;
    logic [31:0] to_base;
    logic        report;
    logic [63:0] record;
    logic [3:0]  wr_idx;
    logic        inhibit;
    logic [5:0]  mask;
    logic [31:0] gsp_base;
    logic        enable;
    logic        irq;
    logic [31:0] prdata;
    logic        apb_ack;
  } blk_state_t;

  blk_state_t s_reg, s_next;

  logic        mp_start;
  logic        mp_write;
  logic [31:0] mp_addr;
  logic [31:0] mp_wdata;
  logic        mp_done;
  logic [31:0] mp_rdata;
  logic        fifo_pop;
  logic        fifo_push;
  logic [63:0] fifo_head;
  logic        fifo_empty;
  logic        fifo_full;
  logic [4:0]  fifo_level;

  // Dword offset to byte address inside the global status page
  function automatic logic [31:0] gsp_addr(input logic [31:0] base, input logic [31:0] dw);
    gsp_addr = base + (dw << 2);
  endfunction : gsp_addr

  // ---------------------------------------------------------------
  // Sub-blocks
  // ---------------------------------------------------------------
  ctx_mem_port u_mem (
    .pclk        (pclk),
    .presetn     (presetn),
    .start       (mp_start),
    .start_write (mp_write),
    .start_addr  (mp_addr),
    .start_wdata (mp_wdata),
    .mem_ack     (mem_ack),
    .mem_rdata   (mem_rdata),
    .mem_req     (mem_req),
    .mem_we      (mem_we),
    .mem_addr    (mem_addr),
    .mem_wdata   (mem_wdata),
    .done        (mp_done),
    .rdata       (mp_rdata)
  );

  ctx_record_fifo #(.WIDTH(64), .DEPTH(FIFO_DEPTH)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .push      (fifo_push),
    .push_data (s_reg.record),
    .pop       (fifo_pop),
    .head_data (fifo_head),
    .empty     (fifo_empty),
    .full      (fifo_full),
    .level     (fifo_level)
  );

  // ---------------------------------------------------------------
  // Sequencer and registers
  // ---------------------------------------------------------------
  always_comb begin
    logic        rd;
    logic        wr;
    logic        word_last;
    logic        kind_ok;
    s_next    = s_reg;
    mp_start  = 1'b0;
    mp_write  = 1'b0;
    mp_addr   = '0;
    mp_wdata  = '0;
    fifo_push = 1'b0;
    fifo_pop  = 1'b0;
    // One wait state: data registered first, write lands with pready
    s_next.apb_ack = psel && penable && !s_reg.apb_ack;
    rd        = psel && penable && !pwrite && !s_reg.apb_ack;
    wr        = psel && penable && pwrite && s_reg.apb_ack;
    word_last = (s_reg.word == 4'(ENGINE_CTX_WORDS - 1));
    kind_ok   = (sw_kind <= 3'(RSN_ACTIVE_IDLE));

    // APB register access; read data stands when pready rises
    s_next.prdata = '0;
    if (rd) begin
      if (paddr == REG_CONTROL_ADDR) begin
        s_next.prdata = {31'h0, s_reg.enable};
      end else if (paddr == REG_REASON_MASK) begin
        s_next.prdata = {26'h0, s_reg.mask};
      end else if (paddr == REG_STATUS_ADDR) begin
        s_next.prdata = {s_reg.run_id, 8'h00, s_reg.wr_idx, s_reg.st};
      end else if (paddr == REG_FIFO_STATUS) begin
        s_next.prdata = {25'h0, fifo_full, fifo_empty, fifo_level};
      end else if (paddr == REG_FIFO_READ_LO) begin
        s_next.prdata = fifo_head[31:0];
      end else if (paddr == REG_FIFO_READ_HI) begin
        s_next.prdata = fifo_head[63:32];
        fifo_pop      = !fifo_empty;
      end else if (paddr == REG_GSP_BASE) begin
        s_next.prdata = s_reg.gsp_base;
      end
    end
    if (wr) begin
      if (paddr == REG_CONTROL_ADDR) begin
        s_next.enable = pwdata[0];
      end else if (paddr == REG_REASON_MASK) begin
        s_next.mask = pwdata[5:0];
      end else if (paddr == REG_GSP_BASE) begin
        s_next.gsp_base = pwdata;
      end
    end

    // Each memory step issues once, then waits for its completion
    if (s_reg.st != ST_IDLE && s_reg.st != ST_IRQ && !s_reg.issued && !mp_done) begin
      s_next.issued = 1'b1;
      mp_start      = 1'b1;
    end
    if (mp_done) begin
      s_next.issued = 1'b0;
    end

    s_next.irq = 1'b0;
    case (s_reg.st)
      ST_IDLE: begin
        if (sw_valid && kind_ok && s_reg.enable) begin
          s_next.to_id   = sw_to_id;
          s_next.to_base = sw_to_base;
          s_next.word    = '0;
          s_next.report  = !s_reg.mask[sw_kind];
          case (sw_kind)
            RSN_IDLE_TO_ACTIVE: s_next.record = pack_record(1'b1, IDLE_CTX_ID, sw_to_id, DETAIL_COMPLETE);
            RSN_PREEMPT_IDLE:   s_next.record = pack_record(1'b1, s_reg.run_id, IDLE_CTX_ID, sw_detail);
            RSN_LOAD_SWITCH:    s_next.record = pack_record(1'b1, s_reg.run_id, sw_to_id, sw_detail);
            RSN_LITE_RESTORE:   s_next.record = pack_record(1'b1, s_reg.run_id, s_reg.run_id, DETAIL_COMPLETE);
            RSN_ELEMENT:        s_next.record = pack_record(1'b0, s_reg.run_id, sw_to_id, sw_detail);
            default:            s_next.record = pack_record(1'b0, s_reg.run_id, IDLE_CTX_ID,
                                                            (sw_detail == DETAIL_PREEMPTED) ? 3'h4 : sw_detail);
          endcase
          // Save only when a real context is running; lite restore keeps state
          if (s_reg.run_id != IDLE_CTX_ID && sw_kind != 3'(RSN_LITE_RESTORE)) begin
            s_next.st = ST_SAVE_RING;
          end else if (sw_kind == 3'(RSN_IDLE_TO_ACTIVE) || sw_kind == 3'(RSN_LOAD_SWITCH)
                       || sw_kind == 3'(RSN_ELEMENT)) begin
            s_next.st = ST_REST_RING;
          end else begin
            s_next.st = ST_REC_LO;
          end
        end
      end
      ST_SAVE_RING: begin
        mp_write = 1'b1;
        mp_addr  = s_reg.run_base + RING_CTX_OFFSET + 32'({s_reg.word, 2'b00});
        mp_wdata = {16'h0, s_reg.run_id};
        if (mp_done) begin
          s_next.word = word_last ? '0 : s_reg.word + 4'h1;
          if (word_last) s_next.st = ST_SAVE_ENG;
        end
      end
      ST_SAVE_ENG: begin
        // Engine context always written in full, even after an inhibited restore
        mp_write = 1'b1;
        mp_addr  = s_reg.run_base + ENGINE_CTX_OFFSET + 32'({s_reg.word, 2'b00});
        mp_wdata = {16'h0, s_reg.run_id};
        if (mp_done) begin
          s_next.word = word_last ? '0 : s_reg.word + 4'h1;
          if (word_last) begin
            s_next.st     = (s_reg.to_id == IDLE_CTX_ID) ? ST_REC_LO : ST_REST_RING;
            s_next.run_id = IDLE_CTX_ID;
          end
        end
      end
      ST_REST_RING: begin
        mp_addr = s_reg.to_base + RING_CTX_OFFSET + 32'({s_reg.word, 2'b00});
        if (mp_done) begin
          if (mp_addr == s_reg.to_base + SR_CTL_WORD_OFFSET) begin
            s_next.inhibit = mp_rdata[SR_INHIBIT_BIT];
          end
          s_next.word = word_last ? '0 : s_reg.word + 4'h1;
          if (word_last) begin
            s_next.st = s_next.inhibit ? ST_REC_LO : ST_REST_ENG;
          end
        end
      end
      ST_REST_ENG: begin
        mp_addr = s_reg.to_base + ENGINE_CTX_OFFSET + 32'({s_reg.word, 2'b00});
        if (mp_done) begin
          s_next.word = word_last ? '0 : s_reg.word + 4'h1;
          if (word_last) s_next.st = ST_REC_LO;
        end
      end
      ST_REC_LO: begin
        if (!s_reg.report) begin
          mp_start      = 1'b0;
          s_next.issued = 1'b0;
          s_next.st     = ST_IDLE;
        end else begin
          mp_write = 1'b1;
          mp_addr  = gsp_addr(s_reg.gsp_base, STATUS_BUF_DW_OFFSET + 32'({s_reg.wr_idx, 1'b0}));
          mp_wdata = s_reg.record[31:0];
          if (mp_done) s_next.st = ST_REC_HI;
        end
        if (s_reg.to_id != IDLE_CTX_ID && s_reg.st == ST_REC_LO) begin
          s_next.run_id   = s_reg.to_id;
          s_next.run_base = s_reg.to_base;
        end
      end
      ST_REC_HI: begin
        mp_write = 1'b1;
        mp_addr  = gsp_addr(s_reg.gsp_base, STATUS_BUF_DW_OFFSET + 32'({s_reg.wr_idx, 1'b1}));
        mp_wdata = s_reg.record[63:32];
        if (mp_done) begin
          s_next.st = ST_LAST_IDX;
          fifo_push = 1'b1;
        end
      end
      ST_LAST_IDX: begin
        mp_write = 1'b1;
        mp_addr  = gsp_addr(s_reg.gsp_base, LAST_IDX_DW_OFFSET);
        mp_wdata = {28'h0, s_reg.wr_idx};
        if (mp_done) begin
          s_next.wr_idx = (s_reg.wr_idx == STATUS_ENTRIES - 4'h1) ? 4'h0 : s_reg.wr_idx + 4'h1;
          s_next.st     = ST_IRQ;
        end
      end
      ST_IRQ: begin
        s_next.irq = 1'b1;
        s_next.st  = ST_IDLE;
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg          <= '0;
      s_reg.st       <= ST_IDLE;
      s_reg.run_id   <= IDLE_CTX_ID;
      s_reg.to_id    <= IDLE_CTX_ID;
      s_reg.mask     <= MASK_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs
  assign sw_ready       = (s_reg.st == ST_IDLE) && s_reg.enable;
  assign ctx_switch_irq = s_reg.irq;
  assign running_id     = s_reg.run_id;
  assign prdata         = s_reg.prdata;
  assign pready         = psel && penable && s_reg.apb_ack;
  assign pslverr        = 1'b0;
endmodule : context_switch_status

// ---- common/ctx_switch_pkg.sv ----
/*
  Shared constants and types for the context switch status block.
  Assumes a 32-bit APB register bus and a simple word-wide memory port.
*/
package ctx_switch_pkg;

  // ---------------------------------------------------------------
  // Context image layout (byte offsets from the descriptor base)
  // ---------------------------------------------------------------
  localparam int unsigned CACHE_LINE_BYTES    = 64;
  localparam int unsigned STATUS_PAGE_BYTES   = 4096;
  localparam int unsigned RING_CTX_LINES      = 5;
  localparam logic [31:0] RING_CTX_OFFSET     = 32'h0000_1000;
  localparam logic [31:0] ENGINE_CTX_OFFSET   = 32'h0000_1140;
  localparam logic [31:0] SR_CTL_WORD_OFFSET  = 32'h0000_1008;
  localparam int unsigned SR_INHIBIT_BIT      = 0;
  localparam int unsigned ENGINE_CTX_WORDS    = 8;

  // ---------------------------------------------------------------
  // Global status page layout (dword offsets)
  // ---------------------------------------------------------------
  localparam logic [31:0] STATUS_BUF_DW_OFFSET = 32'h0000_0028;
  localparam logic [31:0] LAST_IDX_DW_OFFSET   = 32'h0000_0047;
  localparam logic [3:0]  STATUS_ENTRIES       = 4'hC;
  localparam logic [15:0] IDLE_CTX_ID          = 16'hFFFF;

  // ---------------------------------------------------------------
  // APB register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] REG_CONTROL_ADDR   = 12'h000;
  localparam logic [11:0] REG_REASON_MASK    = 12'h004;
  localparam logic [11:0] REG_STATUS_ADDR    = 12'h008;
  localparam logic [11:0] REG_FIFO_STATUS    = 12'h00C;
  localparam logic [11:0] REG_FIFO_READ_LO   = 12'h010;
  localparam logic [11:0] REG_FIFO_READ_HI   = 12'h014;
  localparam logic [11:0] REG_GSP_BASE       = 12'h018;
  localparam logic [5:0]  MASK_RESET         = 6'h00;

  // Switch reason classes, one mask bit each
  typedef enum logic [2:0] {
    RSN_IDLE_TO_ACTIVE,
    RSN_PREEMPT_IDLE,
    RSN_LOAD_SWITCH,
    RSN_LITE_RESTORE,
    RSN_ELEMENT,
    RSN_ACTIVE_IDLE
  } reason_t;

  // Switch detail encodings
  localparam logic [2:0] DETAIL_COMPLETE  = 3'h0;
  localparam logic [2:0] DETAIL_PREEMPTED = 3'h5;

  // Assemble a 64-bit switch-reason record
  function automatic logic [63:0] pack_record(input logic        new_q,
                                              input logic [15:0] away,
                                              input logic [15:0] to,
                                              input logic [2:0]  detail);
    pack_record = {new_q, 12'h000, detail, to, away, 16'h0000};
  endfunction : pack_record

endpackage : ctx_switch_pkg

// ---- src/ctx_record_fifo.sv ----
/*
  Small record queue that the firmware drains through the read port.
  Assumes pop only when not empty; push when full drops the record.
*/
`timescale 1ns/100ps
module ctx_record_fifo
  import ctx_switch_pkg::*;
#(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] head_data,
  output logic                  empty,
  output logic                  full,
  output logic            [4:0] level
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
    logic [4:0]                  cnt;
  } fifo_state_t;

  fifo_state_t state_reg, state_next;

  // Pointer wrap shared by both ends
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb begin
    logic do_push;
    logic do_pop;
    do_push    = push && (state_reg.cnt != 5'(DEPTH));
    do_pop     = pop && (state_reg.cnt != 5'h00);
    state_next = state_reg;
    if (do_push) begin
      state_next.mem[state_reg.wr] = push_data;
      state_next.wr                = bump(state_reg.wr);
    end
    if (do_pop) begin
      state_next.rd = bump(state_reg.rd);
    end
    state_next.cnt = state_reg.cnt + 5'(do_push) - 5'(do_pop);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign head_data = state_reg.mem[state_reg.rd];
  assign empty     = (state_reg.cnt == 5'h00);
  assign full      = (state_reg.cnt == 5'(DEPTH));
  assign level     = state_reg.cnt;
endmodule : ctx_record_fifo

// ---- src/ctx_mem_port.sv ----
/*
  Single-word memory write/read sequencer with request/acknowledge.
  Assumes the memory answers each request with one mem_ack pulse.
*/
`timescale 1ns/100ps
module ctx_mem_port
  import ctx_switch_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic        start_write,
  input  wire logic [31:0] start_addr,
  input  wire logic [31:0] start_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_wdata,
  output logic             done,
  output logic      [31:0] rdata
);
  typedef struct packed {
    logic        busy;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        done;
    logic [31:0] rdata;
  } port_state_t;

  port_state_t state_reg, state_next;

  // Hold request until the memory acknowledges it
  always_comb begin
    state_next      = state_reg;
    state_next.done = 1'b0;
    if (!state_reg.busy && start) begin
      state_next.busy  = 1'b1;
      state_next.we    = start_write;
      state_next.addr  = start_addr;
      state_next.wdata = start_wdata;
    end else if (state_reg.busy && mem_ack) begin
      state_next.busy  = 1'b0;
      state_next.done  = 1'b1;
      state_next.rdata = mem_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign mem_req   = state_reg.busy;
  assign mem_we    = state_reg.we;
  assign mem_addr  = state_reg.addr;
  assign mem_wdata = state_reg.wdata;
  assign done      = state_reg.done;
  assign rdata     = state_reg.rdata;
endmodule : ctx_mem_port

// ---- dv/cs_mem_model.sv ----
/* Word memory on the far side of the block's memory port.
   Assumes one outstanding request, held until acknowledged. */
`timescale 1ns/100ps
module cs_mem_model (
  input  wire logic        pclk,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [31:0] mem_addr,
  input  wire logic        inhibit,
  output logic             mem_ack,
  output logic      [31:0] mem_rdata
);
  int          rd_cnt = 0;
  int          wr_cnt = 0;
  int          wait_q = 0;
  logic [31:0] last_wdata = 32'h0;
  logic [31:0] last_addr = 32'h0;
  initial mem_ack = 1'b0;
  initial mem_rdata = 32'h0;
  // Latency alternates 0 and 3 so both prompt and slow answers occur
  always @(posedge pclk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata; // Garbage outside the ack cycle
    if (mem_req && !mem_ack) begin
      if (wait_q < ((rd_cnt + wr_cnt) % 2) * 3) wait_q <= wait_q + 1;
      else begin
        wait_q <= 0;
        mem_ack <= 1'b1;
        mem_rdata <= inhibit ? 32'hFFFF_FFFF : 32'h0; // Inhibit bit in restored control
        if (mem_we) begin
          wr_cnt++;
          last_wdata <= mem_wdata;
          last_addr <= mem_addr;
        end else rd_cnt++;
      end
    end
  end
endmodule : cs_mem_model

// ---- dv/context_switch_status_checker.sv ----
/* Port-level assertions for the context switch status block.
   Assumes binding onto the top module; sees its ports only. */
`timescale 1ns/100ps
module context_switch_status_checker
  import ctx_switch_pkg::*;
#(parameter int FIFO_DEPTH = 8) (
  input wire logic        pclk, presetn, psel, penable, pready, pslverr,
  input wire logic        sw_valid, sw_ready, mem_req, mem_we, mem_ack, ctx_switch_irq,
  input wire logic [31:0] mem_wdata,
  input wire logic [15:0] running_id
);
  logic [3:0] since_wr;
  // Cycles since the last acknowledged write, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_wr <= 4'hF;
    else if (mem_ack && mem_we) since_wr <= 4'h0;
    else if (since_wr != 4'hF) since_wr <= since_wr + 4'h1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_irq_pulse: assert property (ctx_switch_irq |=> !ctx_switch_irq)
    else $error("irq wider than one cycle");
  a_irq_after_wr: assert property (ctx_switch_irq |-> since_wr < 4'h8)
    else $error("irq without a just committed write");
  a_irq_mem_quiet: assert property (ctx_switch_irq |-> !mem_req)
    else $error("irq while memory still busy");
  a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_we) && $stable(mem_wdata))
    else $error("memory request dropped or changed");
  a_busy_refuse: assert property (mem_req |-> !sw_ready)
    else $error("new switch taken mid sequence");
  a_apb_ready: assert property (psel && penable && !pready |=> pready)
    else $error("pready later than one wait state");
  a_apb_gate: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_no_slverr: assert property (!pslverr)
    else $error("unexpected slave error");
  a_id_hold: assert property (sw_ready && !sw_valid |=> $stable(running_id))
    else $error("running id moved without a switch");
endmodule : context_switch_status_checker
bind context_switch_status context_switch_status_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.pclk, .presetn,
  .psel, .penable, .pready, .pslverr, .sw_valid, .sw_ready, .mem_req, .mem_we, .mem_ack, .ctx_switch_irq,
  .mem_wdata, .running_id);

// ---- dv/test_context_switch_status.sv ----
/* Self-checking bench: switch table loop, then mask and inhibit cases.
   Assumes the memory model above and APB answers after one wait state. */
`timescale 1ns/100ps
module test_context_switch_status;
  import ctx_switch_pkg::*;
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin miscompares++; $display("CHECK FAILED t=%0t %s", $time, m); end end
  typedef struct packed { logic [2:0] k; logic [15:0] to; logic [2:0] det; logic nq; logic [2:0] xd; } row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sw_valid = 0, inhibit = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, sw_to_base = 32'h0, rd, lo, prdata, mem_addr, mem_wdata, mem_rdata;
  logic [2:0] sw_kind = 3'h0, sw_detail = 3'h0;
  logic [15:0] sw_to_id = 16'h0, running_id, run;
  logic pready, pslverr, sw_ready, mem_req, mem_we, mem_ack, ctx_switch_irq;
  int miscompares = 0, checked = 0, cycles = 0, irqs = 0, rdd, wrd, r1, w1;
  row_t rows [13] = '{
    '{3'h0, 16'h00AB, 3'h0, 1'b1, 3'h0}, // Leave idle
    '{3'h4, 16'h07AC, 3'h0, 1'b0, 3'h0}, // Element, complete
    '{3'h4, 16'h0011, 3'h3, 1'b0, 3'h3}, // Element, failed wait
    '{3'h2, 16'h07BC, 3'h5, 1'b1, 3'h5}, // Load, preempted
    '{3'h2, 16'h0022, 3'h2, 1'b1, 3'h2}, // Load, blocked
    '{3'h3, 16'h0022, 3'h0, 1'b1, 3'h0}, // Lite restore
    '{3'h1, 16'hFFFF, 3'h5, 1'b1, 3'h5}, // Preempt to idle
    '{3'h1, 16'hFFFF, 3'h0, 1'b1, 3'h0}, // Preempt while idle
    '{3'h0, 16'h0033, 3'h0, 1'b1, 3'h0}, // Leave idle
    '{3'h5, 16'hFFFF, 3'h5, 1'b0, 3'h4}, // Active to idle, 5 clamped
    '{3'h0, 16'h0044, 3'h0, 1'b1, 3'h0}, // Leave idle
    '{3'h2, 16'h0055, 3'h0, 1'b1, 3'h0}, // Load, completed
    '{3'h4, 16'h0066, 3'h1, 1'b0, 3'h1}}; // Thirteenth record wraps

  context_switch_status DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sw_valid, .sw_kind, .sw_to_id, .sw_to_base, .sw_detail, .sw_ready, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .ctx_switch_irq, .running_id);
  cs_mem_model MEM (.pclk, .mem_req, .mem_we, .mem_wdata, .mem_addr, .inhibit, .mem_ack, .mem_rdata);

  always #2.5 pclk = ~pclk;
  // Hang guard and irq pulse counter
  always @(posedge pclk) begin
    cycles++;
    if (ctx_switch_irq === 1'b1) irqs++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // Read data taken at the edge where pready is high; an idle edge follows
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Hold the event until taken, then wait for the sequencer to free up
  task automatic ev(input logic [2:0] k, input logic [15:0] to, input logic [2:0] det);
    irqs = 0; rdd = MEM.rd_cnt; wrd = MEM.wr_cnt;
    sw_valid <= 1'b1; sw_kind <= k; sw_to_id <= to; sw_detail <= det; sw_to_base <= {4'h1, to, 12'h000};
    do @(posedge pclk); while (sw_ready !== 1'b1);
    sw_valid <= 1'b0;
    @(posedge pclk);
    do @(posedge pclk); while (sw_ready !== 1'b1);
    // Let the irq counter take the pulse seen at the same edge
    @(posedge pclk);
    rdd = MEM.rd_cnt - rdd; wrd = MEM.wr_cnt - wrd;
  endtask : ev

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(running_id, IDLE_CTX_ID, "idle after reset")
    apb(1'b0, REG_REASON_MASK, 32'h0);
    `CHK(rd[5:0], MASK_RESET, "mask reset")
    apb(1'b0, 12'h100, 32'h0);
    `CHK(rd, 32'h0, "unmapped read")
    apb(1'b1, REG_CONTROL_ADDR, 32'h1);
    run = IDLE_CTX_ID;
    foreach (rows[i]) begin
      ev(rows[i].k, rows[i].to, rows[i].det);
      `CHK(irqs, 1, "irq count")
      `CHK(MEM.last_wdata[7:0], 8'(i % 12), "last index")
      `CHK(MEM.last_addr, LAST_IDX_DW_OFFSET << 2, "index address")
      apb(1'b0, REG_FIFO_READ_LO, 32'h0);
      lo = rd;
      apb(1'b0, REG_FIFO_READ_HI, 32'h0);
      `CHK({rd, lo}, {rows[i].nq, 12'h000, rows[i].xd, rows[i].to, run, 16'h0000}, "record")
      run = rows[i].to;
      `CHK(running_id, run, "running id")
    end
    // Masked element switch leaves no record and no irq
    apb(1'b1, REG_REASON_MASK, 32'h10);
    ev(3'h4, 16'h0077, 3'h0);
    `CHK(irqs, 0, "masked irq")
    apb(1'b0, REG_FIFO_STATUS, 32'h0);
    `CHK(rd[6:0], 7'h20, "masked fifo")
    apb(1'b1, REG_REASON_MASK, 32'h0);
    // First-time context with engine restore inhibited, then a normal one
    inhibit <= 1'b1;
    ev(3'h2, 16'h0088, 3'h0);
    r1 = rdd; w1 = wrd;
    inhibit <= 1'b0;
    ev(3'h2, 16'h0099, 3'h0);
    `CHK(r1 < rdd, 1'b1, "inhibit skips engine restore")
    `CHK(w1, wrd, "full save after inhibit")
    finish_test();
  end
endmodule : test_context_switch_status
